// >>> testbench/tb_top.sv
// Purpose: Self-checking bench of the tile reset sequencer
// Assumes: APB master tasks, tile model on status pins
// Notes: Inputs change on rising edges, APB outputs and outputs checked right after an APB transfer sampled on rising, other outputs on falling
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import trs_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic tile_reset, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NCH-1:0] pattern_error_flag, oversampler_error_flag;
    trs_tile_in_s drv, tile_in;
    trs_comp_s [NCH-1:0] comp_reset;
    int n_fail, samples_checked, n, b;
    int ebit [9] = '{12, 6, 7, 4, 5, 2, 3, 0, 1};
    trs_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tile_in(tile_in), .tile_reset(tile_reset), .comp_reset(comp_reset),
        .pattern_error_flag(pattern_error_flag),
        .oversampler_error_flag(oversampler_error_flag), .irq(irq));
    trs_tile_model i_tile (.pclk(pclk), .presetn(presetn),
        .tile_reset(tile_reset), .comp_reset(comp_reset), .drv(drv),
        .tile_in(tile_in));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task fail_to(input string m);
        n_fail++;
        $display("unexpected at %0t: timeout %s", $time, m);
        end_sim();
    endtask : fail_to
    task chk_word(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s %h not %h", $time, m, got, exp);
        end
    endtask : chk_word
    task chk_bit(input logic got, input logic exp, input string m);
        chk_word({31'h0, got}, {31'h0, exp}, m);
    endtask : chk_bit
    task tick(input int k);
        repeat (k) @(negedge pclk);
    endtask : tick
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            t++;
            if (t > 50) fail_to("apb");
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic pick(input int s);
        case (s)
            0: return irq;
            1: return tile_reset;
            2: return comp_reset[0].cdr;
            default: return comp_reset[0].ebuf;
        endcase
    endfunction : pick
    task wait_lvl(input int s, input logic lvl, output int k);
        k = 0;
        @(negedge pclk);
        while (pick(s) !== lvl) begin
            k++;
            if (k > 200) fail_to("level");
            @(negedge pclk);
        end
    endtask : wait_lvl
    function automatic logic [5:0] exp_comp(input int bit_i);
        case (bit_i)
            CH_TX: return 6'h20;
            CH_RX: return 6'h1e;
            CH_EBUF: return 6'h08;
            CH_CDR: return 6'h01;
            default: return 6'h04;
        endcase
    endfunction : exp_comp
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #2500000;
        fail_to("run");
    end
    initial begin
        n_fail = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        drv = '0;
        drv.user_clk_lock = 1'b1;
        drv.rx_idle = 2'b11;
        repeat (11) @(posedge pclk);
        tick(1);
        chk_bit(tile_reset, 1'b1, "tile in reset");
        chk_word({20'h0, comp_reset}, 32'hfff, "lanes in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        wait_lvl(1, 1'b0, n);
        chk_bit(n >= POR_CYCLES - 1 && n <= POR_CYCLES + 1, 1'b1, "por");
        chk_word({20'h0, comp_reset}, 32'h0, "lanes out");
        $display("test power-up done");
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk_word(rd, {27'h0, CTRL_RST}, "ctrl");
        apb(1'b0, ADDR_IRQ_EN, 32'h0);
        chk_word(rd, {20'h0, IRQ_EN_RST}, "irq en");
        apb(1'b0, ADDR_IRQ_CLR, 32'h0);
        chk_bit(err, 1'b0, "clear read");
        apb(1'b1, 8'h1c, 32'hffffffff);
        chk_bit(err, 1'b1, "unmapped write");
        apb(1'b0, ADDR_STAT, 32'h0);
        chk_word(rd, 32'h0000000f, "status");
        $display("test registers done");
        for (int c = 0; c < NCH; c++) begin
            for (int k = 0; k < 5; k++) begin
                apb(1'b1, ADDR_CHRST, 32'h1 << (k + c * CH1_LSB));
                tick(2);
                chk_word({20'h0, comp_reset}, 32'(exp_comp(k)) << (6 * c),
                    "lane reset");
                chk_bit(tile_reset, 1'b0, "tile kept");
            end
        end
        apb(1'b1, ADDR_CHRST, 32'h0);
        tick(2);
        chk_word({20'h0, comp_reset}, 32'h0, "lanes freed");
        $display("test lane resets done");
        apb(1'b1, ADDR_IRQ_CLR, 32'hfff);
        apb(1'b1, ADDR_IRQ_EN, 32'hfff);
        for (int k = 1; k < 10; k++) begin
            b = ebit[k-1];
            if (k == 1) apb(1'b1, ADDR_CHRST, 32'h303);
            @(posedge pclk);
            drv[b] <= ~drv[b];
            repeat (4) @(posedge pclk);
            drv[b] <= ~drv[b];
            tick(6);
            apb(1'b0, ADDR_IRQ_ST, 32'h0);
            chk_word(rd, 32'h1 << k, "event status");
            chk_bit(irq, 1'b1, "irq up");
            if (k == 1) begin
                chk_word({20'h0, comp_reset}, 32'hfbe, "pcs held");
                apb(1'b1, ADDR_CHRST, 32'h0);
            end
            if (k == 2) begin
                apb(1'b1, ADDR_IRQ_EN, 32'h0);
                tick(2);
                chk_bit(irq, 1'b0, "irq masked");
                apb(1'b1, ADDR_IRQ_EN, 32'hfff);
                tick(2);
                chk_bit(irq, 1'b1, "irq unmasked");
            end
            if (k == 6 || k == 7) begin
                chk_bit(pattern_error_flag[k-6], 1'b1, "sticky");
                apb(1'b1, ADDR_ERRCLR, 32'h1 << (k - 6));
                tick(2);
                chk_bit(pattern_error_flag[k-6], 1'b0, "cleared");
            end
            if (k > 7) begin
                chk_bit(oversampler_error_flag[k-8], 1'b1, "ovs");
                apb(1'b1, ADDR_CHRST, 32'h1 << (CH_RX + (k - 8) * CH1_LSB));
                tick(3);
                chk_bit(oversampler_error_flag[k-8], 1'b0, "ovs clr");
                apb(1'b1, ADDR_CHRST, 32'h0);
            end
            apb(1'b1, ADDR_IRQ_CLR, 32'h1 << k);
            tick(2);
            chk_bit(irq, 1'b0, "irq down");
        end
        $display("test events done");
        apb(1'b1, ADDR_CTRL, 32'h06);
        @(posedge pclk);
        drv.rx_idle[1] <= 1'b0;
        tick(20);
        chk_bit(comp_reset[1].cdr, 1'b0, "no auto reset");
        @(posedge pclk);
        drv.rx_idle[1] <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h1e);
        @(posedge pclk);
        drv.rx_idle <= 2'b00;
        wait_lvl(2, 1'b1, n);
        chk_bit(n <= 8, 1'b1, "auto reset start");
        chk_bit(comp_reset[1].cdr, 1'b1, "lane 1 auto reset");
        wait_lvl(2, 1'b0, n);
        chk_word(32'(n + 1), 32'(CDR_RST_CYCLES), "cdr len");
        wait_lvl(3, 1'b1, n);
        chk_bit(tile_in.cdr_lock[0], 1'b1, "buf after lock");
        wait_lvl(3, 1'b0, n);
        chk_word(32'(n + 1), 32'(BUF_RST_CYCLES), "buf len");
        tick(4);
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        chk_word(rd, 32'hc00, "seq done");
        apb(1'b0, ADDR_STAT, 32'h0);
        chk_word(rd, 32'h0000000f, "ready to bond");
        $display("test idle sequence done");
        apb(1'b1, ADDR_IRQ_CLR, 32'hfff);
        apb(1'b1, ADDR_CTRL, 32'h01);
        tick(2);
        chk_bit(tile_reset, 1'b1, "sw tile reset");
        chk_word({20'h0, comp_reset}, 32'hfff, "all lanes");
        apb(1'b1, ADDR_CTRL, 32'h0);
        wait_lvl(1, 1'b0, n);
        tick(10);
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        chk_bit(rd[0], 1'b1, "pll loss seen");
        $display("test tile reset done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire

// >>> testbench/trs_tile_model.sv
// Purpose: Far-side tile model giving PLL and recovery lock
// Assumes: Lock returns a fixed delay after reset release
// Notes: All other status pins come from the bench
`timescale 1ns/1ps
`default_nettype none
module trs_tile_model
    import trs_pkg::*;
#(
    parameter int LOCK_DLY = 6
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Resets from the sequencer
    input wire logic tile_reset,
    input wire trs_comp_s [NCH-1:0] comp_reset,
    // Pins from the bench
    input wire trs_tile_in_s drv,
    output trs_tile_in_s tile_in
);
    int pll_cnt;
    int cdr_cnt [NCH];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || tile_reset) begin
            pll_cnt <= 0;
        end else if (pll_cnt < LOCK_DLY) begin
            pll_cnt <= pll_cnt + 1;
        end
        for (int c = 0; c < NCH; c++) begin
            if (!presetn || tile_reset || comp_reset[c].cdr) begin
                cdr_cnt[c] <= 0;
            end else if (cdr_cnt[c] < LOCK_DLY) begin
                cdr_cnt[c] <= cdr_cnt[c] + 1;
            end
        end
    end
    always_comb begin
        tile_in = drv;
        tile_in.pll_lock = (pll_cnt == LOCK_DLY);
        for (int c = 0; c < NCH; c++) begin
            tile_in.cdr_lock[c] = (cdr_cnt[c] == LOCK_DLY);
        end
    end
endmodule : trs_tile_model
`default_nettype wire

// >>> verilog/trs_pkg.sv
// Purpose: Shared constants and types of the tile reset sequencer
// Assumes: pclk at 40 MHz
// Notes: Offsets are APB byte addresses
package trs_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int POR_TIME_NS = 1000;
    localparam int CDR_RST_TIME_NS = 200;
    localparam int BUF_RST_TIME_NS = 100;
    localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CDR_RST_CYCLES = (CDR_RST_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int BUF_RST_CYCLES = (BUF_RST_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam int NCH = 2;
    localparam int NIRQ = 12;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CHRST = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_ERRCLR = 8'h18;
    localparam int CTRL_TILE = 0;
    localparam int CTRL_PH = 1;
    localparam int CTRL_FR = 2;
    localparam int CTRL_HOLD = 3;
    localparam int CTRL_ABUF = 4;
    localparam int CH_TX = 0;
    localparam int CH_RX = 1;
    localparam int CH_EBUF = 2;
    localparam int CH_CDR = 3;
    localparam int CH_PCNT = 4;
    localparam int CH1_LSB = 8;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [4:0] CHRST_RST = 5'h00;
    localparam logic [NIRQ-1:0] IRQ_EN_RST = 12'h000;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_CDR = 2'b01,
        SEQ_LOCK = 2'b10,
        SEQ_BUF = 2'b11
    } trs_seq_e;
    typedef struct packed {
        logic tx_pcs;
        logic rx_pcs;
        logic ebuf;
        logic pchk;
        logic ovs;
        logic cdr;
    } trs_comp_s;
    typedef struct packed {
        logic pll_lock;
        logic user_clk_lock;
        logic [1:0] cdr_lock;
        logic [1:0] rx_idle;
        logic [1:0] tx_buf_err;
        logic [1:0] rx_buf_err;
        logic [1:0] pattern_over;
        logic [1:0] ovs_fault;
    } trs_tile_in_s;
endpackage : trs_pkg

// >>> verilog/trs_por.sv
// Purpose: Tile reset after configuration
// Assumes: presetn release marks end of configuration
// Notes: Output high from reset until count expires
`timescale 1ns/1ps
`default_nettype none
module trs_por
    import trs_pkg::*;
#(
    parameter int CYCLES = POR_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Status
    output logic busy
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic busy;
    } trs_por_s;
    trs_por_s s_r, s_nxt;

    // RULE1: automatic tile reset
    always_comb begin
        s_nxt = s_r;
        if (s_r.busy) begin
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (s_r.cnt == CNT_W'(CYCLES - 1)) begin
                s_nxt.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{cnt: '0, busy: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;

    a_por_length: assert property ( // RULE1
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> busy [*8])
        else $error("tile reset after configuration too short");
endmodule : trs_por
`default_nettype wire

// >>> verilog/trs_sync.sv
// Purpose: Two-stage synchroniser for tile status pins
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module trs_sync
    import trs_pkg::*;
#(
    parameter int W = 14
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } trs_sync_s;
    trs_sync_s s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = d;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.stable;
endmodule : trs_sync
`default_nettype wire

// >>> verilog/trs_top.sv
// Purpose: Reset sequencer of a dual-channel transceiver tile
// Assumes: APB slave on pclk; tile status pins are asynchronous
// Notes: Per-channel vectors index channel 0 at bit 0
// Contract
// RULE1: Tile resets itself after configuration
// RULE2: Late clock power-up needs tile reset
// RULE3: Reference clock change needs tile reset
// RULE4: Hold PCS resets while clock unlocked
// RULE5: Redo phase alignment after clock relock
// RULE6: Remote power-up resets clock recovery
// RULE7: Idle options enable automatic recovery reset
// RULE8: Plug-in resets receiver clock recovery
// RULE9: TX buffer error needs TX reset
// RULE10: RX buffer error needs buffer reset
// RULE11: Bonded lanes share one clock source
// RULE12: No bonding before clock is stable
// RULE13: Bonded sources share reference, lanes locked
// RULE14: Recovery reset, lock, buffer reset, bond
// RULE15: Pattern error flag sticky until cleared
// RULE16: Oversampler flag set, cleared by RX reset
// RULE17: Choose least disturbing reset
// RULE18: Each reset clears only its components
// RULE19: Resets held levels, released after lock
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module trs_top
    import trs_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Tile status pins
    input wire trs_tile_in_s tile_in,
    // Tile resets
    output logic tile_reset,
    output trs_comp_s [NCH-1:0] comp_reset,
    // Flags and interrupt
    output logic [NCH-1:0] pattern_error_flag,
    output logic [NCH-1:0] oversampler_error_flag,
    output logic irq
);
    typedef struct packed {
        logic [4:0] ctrl;
        logic [NCH-1:0][4:0] chrst;
        logic [NIRQ-1:0] irq_en;
        logic [NIRQ-1:0] irq_st;
        logic [NCH-1:0] pat_err;
        logic [NCH-1:0] ovs_err;
        trs_seq_e [NCH-1:0] seq;
        logic [NCH-1:0][CNT_W-1:0] cnt;
        trs_tile_in_s prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic tile;
        trs_comp_s [NCH-1:0] comp;
        logic irq;
    } trs_state_s;
    trs_state_s s_r, s_nxt;
    trs_tile_in_s tin;
    logic [$bits(trs_tile_in_s)-1:0] sync_q;
    logic por_busy;

    // ------------------------------------------------------------
    // Input synchronisers and configuration reset
    // ------------------------------------------------------------
    trs_sync #(.W($bits(trs_tile_in_s))) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(tile_in),
        .q(sync_q)
    );
    assign tin = trs_tile_in_s'(sync_q);

    trs_por #(.CYCLES(POR_CYCLES)) u_por (
        .pclk(pclk),
        .presetn(presetn),
        .busy(por_busy)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_phase;
    logic idle_opts;
    logic tile_nxt;
    logic [NIRQ-1:0] ev;
    logic [NCH-1:0] pat_clr;
    assign wr_en = psel && penable && pwrite && s_r.pready;
    assign rd_phase = psel && penable && !s_r.pready;
    assign idle_opts = s_r.ctrl[CTRL_PH] && s_r.ctrl[CTRL_FR]
        && s_r.ctrl[CTRL_HOLD];

    always_comb begin
        s_nxt = s_r;
        ev = '0;
        pat_clr = '0;
        s_nxt.prev = tin;
        // Bus handshake: one wait state, data registered
        s_nxt.pready = rd_phase;
        s_nxt.pslverr = 1'b0;
        if (rd_phase) begin
            s_nxt.prdata = 32'h0000_0000;
            unique case (paddr)
                ADDR_CTRL: s_nxt.prdata[4:0] = s_r.ctrl;
                ADDR_CHRST: begin
                    s_nxt.prdata[4:0] = s_r.chrst[0];
                    s_nxt.prdata[CH1_LSB+:5] = s_r.chrst[1];
                end
                ADDR_STAT: s_nxt.prdata[12:0] = {por_busy, s_r.seq,
                    s_r.ovs_err, s_r.pat_err, tin.cdr_lock,
                    tin.user_clk_lock, tin.pll_lock};
                ADDR_IRQ_ST: s_nxt.prdata[NIRQ-1:0] = s_r.irq_st;
                ADDR_IRQ_EN: s_nxt.prdata[NIRQ-1:0] = s_r.irq_en;
                ADDR_IRQ_CLR, ADDR_ERRCLR: ;
                default: s_nxt.pslverr = 1'b1;
            endcase
        end else if (s_r.pready) begin
            s_nxt.pslverr = s_r.pslverr;
        end
        if (wr_en && !s_r.pslverr) begin
            unique case (paddr)
                ADDR_CTRL: s_nxt.ctrl = pwdata[4:0];
                ADDR_CHRST: begin
                    s_nxt.chrst[0] = pwdata[4:0];
                    s_nxt.chrst[1] = pwdata[CH1_LSB+:5];
                end
                ADDR_IRQ_CLR: s_nxt.irq_st = s_r.irq_st
                    & ~pwdata[NIRQ-1:0];
                ADDR_IRQ_EN: s_nxt.irq_en = pwdata[NIRQ-1:0];
                ADDR_ERRCLR: pat_clr = pwdata[NCH-1:0];
                default: ;
            endcase
        end
        // RULE1: tile reset after configuration
        tile_nxt = por_busy || s_r.ctrl[CTRL_TILE];
        s_nxt.tile = tile_nxt;
        ev[0] = s_r.prev.pll_lock && !tin.pll_lock;
        ev[1] = s_r.prev.user_clk_lock && !tin.user_clk_lock;
        for (int c = 0; c < NCH; c++) begin
            ev[2+c] = tin.tx_buf_err[c] && !s_r.prev.tx_buf_err[c];
            ev[4+c] = tin.rx_buf_err[c] && !s_r.prev.rx_buf_err[c];
            ev[6+c] = tin.pattern_over[c]
                && !s_r.prev.pattern_over[c];
            ev[8+c] = tin.ovs_fault[c] && !s_r.prev.ovs_fault[c];
            // RULE7: idle-exit recovery sequencer
            unique case (s_r.seq[c])
                SEQ_IDLE: begin
                    if (idle_opts && s_r.prev.rx_idle[c]
                        && !tin.rx_idle[c]) begin
                        s_nxt.seq[c] = SEQ_CDR;
                        s_nxt.cnt[c] = '0;
                    end
                end
                SEQ_CDR: begin
                    s_nxt.cnt[c] = s_r.cnt[c] + 8'h01;
                    if (s_r.cnt[c] == CNT_W'(CDR_RST_CYCLES - 1)) begin
                        s_nxt.seq[c] = SEQ_LOCK;
                    end
                end
                SEQ_LOCK: begin
                    // RULE14: buffer reset only after lock
                    if (tin.cdr_lock[c]) begin
                        s_nxt.cnt[c] = '0;
                        s_nxt.seq[c] = s_r.ctrl[CTRL_ABUF]
                            ? SEQ_BUF : SEQ_IDLE;
                        ev[10+c] = !s_r.ctrl[CTRL_ABUF];
                    end
                end
                SEQ_BUF: begin
                    s_nxt.cnt[c] = s_r.cnt[c] + 8'h01;
                    if (s_r.cnt[c] == CNT_W'(BUF_RST_CYCLES - 1)) begin
                        s_nxt.seq[c] = SEQ_IDLE;
                        ev[10+c] = 1'b1;
                    end
                end
            endcase
            if (tile_nxt) begin
                s_nxt.seq[c] = SEQ_IDLE;
            end
            // RULE18: reset fan-out per component
            s_nxt.comp[c].tx_pcs = tile_nxt || s_r.chrst[c][CH_TX];
            s_nxt.comp[c].rx_pcs = tile_nxt || s_r.chrst[c][CH_RX];
            s_nxt.comp[c].ovs = tile_nxt || s_r.chrst[c][CH_RX];
            s_nxt.comp[c].ebuf = tile_nxt || s_r.chrst[c][CH_RX]
                || s_r.chrst[c][CH_EBUF] || s_r.seq[c] == SEQ_BUF;
            s_nxt.comp[c].pchk = tile_nxt || s_r.chrst[c][CH_RX]
                || s_r.chrst[c][CH_PCNT];
            // RULE6: recovery reset on remote power-up
            // RULE8: recovery reset on plug-in
            s_nxt.comp[c].cdr = tile_nxt || s_r.chrst[c][CH_CDR]
                || s_r.seq[c] == SEQ_CDR;
            // RULE15: sticky until cleared, set wins
            if (pat_clr[c] || s_r.comp[c].pchk) begin
                s_nxt.pat_err[c] = 1'b0;
            end
            if (ev[6+c]) begin
                s_nxt.pat_err[c] = 1'b1;
            end
            // RULE16: cleared by RX reset, set wins
            if (s_r.comp[c].rx_pcs) begin
                s_nxt.ovs_err[c] = 1'b0;
            end
            if (ev[8+c]) begin
                s_nxt.ovs_err[c] = 1'b1;
            end
        end
        s_nxt.irq_st = s_nxt.irq_st | ev;
        s_nxt.irq = |(s_r.irq_st & s_r.irq_en);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.chrst <= {CHRST_RST, CHRST_RST};
            s_r.irq_en <= IRQ_EN_RST;
            s_r.tile <= 1'b1;
            s_r.comp <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign tile_reset = s_r.tile;
    assign comp_reset = s_r.comp;
    assign pattern_error_flag = s_r.pat_err;
    assign oversampler_error_flag = s_r.ovs_err;
    assign irq = s_r.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_idle_exit(int c);
        idle_opts && s_r.seq[c] == SEQ_IDLE && !tile_nxt
            && s_r.prev.rx_idle[c] && !tin.rx_idle[c];
    endsequence
    sequence s_cdr_pulse(int c);
        ##1 s_r.seq[c] == SEQ_CDR ##1 comp_reset[c].cdr [*8];
    endsequence

    a_tile_clears_all: assert property ( // RULE18
        tile_reset |-> &comp_reset)
        else $error("tile reset did not reset every component");
    a_ebuf_alone: assert property ( // RULE18
        s_r.chrst[0] == 5'h04 && !tile_nxt && s_r.seq[0] == SEQ_IDLE
        |=> comp_reset[0].ebuf && !comp_reset[0].rx_pcs
            && !comp_reset[0].cdr && !comp_reset[0].tx_pcs)
        else $error("buffer reset disturbed other components");
    a_seq_cdr_ch0: assert property ( // RULE7
        s_idle_exit(0) |-> s_cdr_pulse(0))
        else $error("recovery reset not issued after idle exit");
    a_seq_cdr_ch1: assert property ( // RULE6
        s_idle_exit(1) |-> s_cdr_pulse(1))
        else $error("recovery reset not issued on channel 1");
    a_buf_after_lock: assert property ( // RULE14
        s_r.seq[0] == SEQ_LOCK && tin.cdr_lock[0] && s_r.ctrl[CTRL_ABUF]
        && !tile_nxt |=> ##1 comp_reset[0].ebuf [*4])
        else $error("buffer reset missing after recovery lock");
    a_pat_sticky: assert property ( // RULE15
        pattern_error_flag[0] && !pat_clr[0] && !s_r.comp[0].pchk
        |=> pattern_error_flag[0])
        else $error("pattern error flag dropped without clear");
    a_pat_clear: assert property ( // RULE15
        pat_clr[0] && !ev[6] |=> !pattern_error_flag[0])
        else $error("pattern error clear ignored");
    a_ovs_set_clear: assert property ( // RULE16
        (ev[8] |=> oversampler_error_flag[0]) and
        (s_r.comp[0].rx_pcs && !ev[8] |=> !oversampler_error_flag[0]))
        else $error("oversampler flag wrong");
    a_irq_level: assert property (
        |(s_r.irq_st & s_r.irq_en) |=> irq)
        else $error("interrupt not raised");
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_tile_after_por: assert property ( // RULE1
        por_busy |=> tile_reset)
        else $error("tile reset not held during configuration reset");
    a_lock_wait: assert property ( // RULE14
        s_r.seq[0] == SEQ_LOCK && !tin.cdr_lock[0] && !tile_nxt
        && s_r.chrst[0] == 5'h00
        |=> s_r.seq[0] == SEQ_LOCK && !comp_reset[0].ebuf)
        else $error("buffer reset before recovery lock");
endmodule : trs_top
`default_nettype wire
